/* logic/command_interrupt_control.sv */
// Interrupt enable, vector and handler return logic for a command engine
//
// Behaviour
// [R1] Code 25 enables the interrupt named in the type field.
// [R2] Enable with number 255 sets the global enable instead of a single one.
// [R3] Code 26 clears the enable of the interrupt named in the type field.
// [R4] Disable with number 255 clears the global enable.
// [R5] Code 37 stores the value field as entry address for that number.
// [R6] A later vector definition for the same number overwrites the old one.
// [R7] Code 38 restores saved accumulator, X, flags and counter and resumes.
// [R8] Each of the four commands in direct mode is answered with status 100.
// [R9] The program must end each handler with a return and never run into one.
// [R10] Vector definition and return are meant for stored programs only; the code also executes them from host frames.
// [R11] An interrupt with both enables set saves context and jumps when no handler is already running.
// [R12] A frame ends in a checksum, the 8-bit sum of its first eight bytes.
`timescale 1ns/1ps
module command_interrupt_control #(
  parameter int IRQ_COUNT = irq_ctrl_pkg::IRQ_COUNT,
  parameter int IRQ_IDX_W = irq_ctrl_pkg::IRQ_IDX_W,
  parameter int PC_W      = irq_ctrl_pkg::PC_W
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  // Direct-mode frame bytes from the host
  input  wire logic                 frame_valid_i,
  input  wire logic [7:0]           frame_byte_i,
  // Decoded instruction from the stored program
  input  wire logic                 prog_valid_i,
  input  wire logic [7:0]           prog_op_i,
  input  wire logic [7:0]           prog_type_i,
  input  wire logic [31:0]          prog_value_i,
  // Interrupt sources and interpreter context
  input  wire logic [IRQ_COUNT-1:0] irq_req_i,
  input  wire logic [31:0]          accu_i,
  input  wire logic [31:0]          xreg_i,
  input  wire logic [7:0]           flags_i,
  input  wire logic [PC_W-1:0]      pc_i,
  // Reply to the host
  output logic                      reply_valid_o,
  output logic [7:0]                reply_status_o,
  output logic [7:0]                reply_cmd_o,
  // Context load toward the interpreter
  output logic                      ctx_load_o,
  output logic [31:0]               accu_o,
  output logic [31:0]               xreg_o,
  output logic [7:0]                flags_o,
  output logic [PC_W-1:0]           pc_o,
  // Status
  output logic                      global_en_o,
  output logic [IRQ_COUNT-1:0]      irq_en_o,
  output logic                      in_handler_o
);
  // ****************************************************************
  // Frame assembly
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_JUMP} irq_state_e;

  logic [7:0]  frame [irq_ctrl_pkg::FRAME_BYTES];
  logic [3:0]  byte_cnt;
  logic [7:0]  sum;
  logic        frame_done;

  // Collect nine bytes, summing the first eight
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      byte_cnt   <= 4'h0;
      sum        <= 8'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (frame_valid_i) begin
        frame[byte_cnt] <= frame_byte_i;
        if (byte_cnt == 4'(irq_ctrl_pkg::FRAME_BYTES - 1)) begin
          byte_cnt   <= 4'h0;
          frame_done <= 1'b1;
        end else begin
          byte_cnt <= byte_cnt + 4'h1;
          sum      <= (byte_cnt == 4'h0) ? frame_byte_i
                                         : sum + frame_byte_i;
        end
      end
    end
  end

  // ****************************************************************
  // Command selection
  // ****************************************************************
  wire        sum_ok     = (frame[8] == sum);  // [R12]
  wire        host_cmd   = frame_done && sum_ok;
  wire        cmd_valid  = host_cmd || prog_valid_i;
  wire [7:0]  cmd_op     = host_cmd ? frame[1] : prog_op_i;
  wire [7:0]  cmd_type   = host_cmd ? frame[2] : prog_type_i;
  wire [31:0] cmd_value  = host_cmd ?
                           {frame[4], frame[5], frame[6], frame[7]} :
                           prog_value_i;
  wire        is_en      = cmd_valid && cmd_op == irq_ctrl_pkg::OP_IRQ_ENABLE;
  wire        is_dis     = cmd_valid && cmd_op == irq_ctrl_pkg::OP_IRQ_DISABLE;
  wire        is_handler_vector_define_cmd    = cmd_valid &&
                           cmd_op == irq_ctrl_pkg::OP_VECTOR_DEFINE;
  wire        is_ret     = cmd_valid &&
                           cmd_op == irq_ctrl_pkg::OP_HANDLER_RETURN;
  wire        is_global  = cmd_type == irq_ctrl_pkg::IRQ_GLOBAL;
  wire        in_range   = cmd_type < 8'(IRQ_COUNT);
  wire [IRQ_IDX_W-1:0] cmd_idx = cmd_type[IRQ_IDX_W-1:0];

  // ****************************************************************
  // Pending interrupt priority, lowest number wins
  // ****************************************************************
  wire [IRQ_COUNT-1:0] armed = irq_req_i & irq_en_o;
  logic [IRQ_IDX_W-1:0] pick;
  always_comb begin
    pick = '0;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (armed[i]) begin
        pick = IRQ_IDX_W'(i);
      end
    end
  end
  wire take_irq = global_en_o && (|armed) && !in_handler_o; // [R11]

  // ****************************************************************
  // Vector memory
  // ****************************************************************
  logic [PC_W-1:0] vec_rd;
  logic [IRQ_IDX_W-1:0] vec_rd_addr;
  irq_state_e state;

  vector_table #(
    .DEPTH (IRQ_COUNT),
    .ADDR_W(IRQ_IDX_W),
    .DATA_W(PC_W)
  ) u_vectors (
    .mclk_i   (mclk_i),
    .wr_en_i  (is_handler_vector_define_cmd && in_range),     // [R5] [R6]
    .wr_addr_i(cmd_idx),
    .wr_data_i(cmd_value[PC_W-1:0]),
    .rd_addr_i(vec_rd_addr),
    .rd_data_o(vec_rd)
  );

  // ****************************************************************
  // Enables
  // ****************************************************************
  // Individual enable bits, one per interrupt number
  for (genvar g = 0; g < IRQ_COUNT; g++) begin : g_en
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        irq_en_o[g] <= 1'b0;
      end else if (is_en && !is_global && cmd_idx == g && in_range) begin
        irq_en_o[g] <= 1'b1;                          // [R1]
      end else if (is_dis && !is_global && cmd_idx == g && in_range) begin
        irq_en_o[g] <= 1'b0;                          // [R3]
      end
    end
  end

  // Global enable
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      global_en_o <= irq_ctrl_pkg::GLOBAL_EN_RESET;
    end else if (is_en && is_global) begin
      global_en_o <= 1'b1;                            // [R2]
    end else if (is_dis && is_global) begin
      global_en_o <= 1'b0;                            // [R4]
    end
  end

  // ****************************************************************
  // Context save, jump and return
  // ****************************************************************
  logic [31:0]     sv_accu;
  logic [31:0]     sv_xreg;
  logic [7:0]      sv_flags;
  logic [PC_W-1:0] sv_pc;

  // Entry takes three cycles because the vector read is registered
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state        <= ST_IDLE;
      in_handler_o <= 1'b0;
      ctx_load_o   <= 1'b0;
      accu_o       <= 32'h0000_0000;
      xreg_o       <= 32'h0000_0000;
      flags_o      <= 8'h00;
      pc_o         <= irq_ctrl_pkg::PC_RESET;
      sv_accu      <= 32'h0000_0000;
      sv_xreg      <= 32'h0000_0000;
      sv_flags     <= 8'h00;
      sv_pc        <= irq_ctrl_pkg::PC_RESET;
      vec_rd_addr  <= '0;
    end else begin
      ctx_load_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (is_ret && in_handler_o) begin
            accu_o       <= sv_accu;                  // [R7]
            xreg_o       <= sv_xreg;
            flags_o      <= sv_flags;
            pc_o         <= sv_pc;
            ctx_load_o   <= 1'b1;
            in_handler_o <= 1'b0;
          end else if (take_irq) begin
            sv_accu  <= accu_i;                       // [R11]
            sv_xreg  <= xreg_i;
            sv_flags <= flags_i;
            sv_pc    <= pc_i;
            vec_rd_addr <= pick;                      // Held: no late change
            state    <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state <= ST_JUMP;
        end
        ST_JUMP: begin
          accu_o       <= sv_accu;
          xreg_o       <= sv_xreg;
          flags_o      <= sv_flags;
          pc_o         <= vec_rd;                     // [R11]
          ctx_load_o   <= 1'b1;
          in_handler_o <= 1'b1;
          state        <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Direct-mode reply
  // ****************************************************************
  wire known_op = frame[1] == irq_ctrl_pkg::OP_IRQ_ENABLE ||
                  frame[1] == irq_ctrl_pkg::OP_IRQ_DISABLE ||
                  frame[1] == irq_ctrl_pkg::OP_VECTOR_DEFINE ||
                  frame[1] == irq_ctrl_pkg::OP_HANDLER_RETURN;
  wire [7:0] next_status = !sum_ok   ? irq_ctrl_pkg::STATUS_BAD_SUM :
                           !known_op ? irq_ctrl_pkg::STATUS_BAD_CMD :
                                       irq_ctrl_pkg::STATUS_OK;

  // One reply per completed frame
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reply_valid_o  <= 1'b0;
      reply_status_o <= 8'h00;
      reply_cmd_o    <= 8'h00;
    end else begin
      reply_valid_o <= frame_done;
      if (frame_done) begin
        reply_status_o <= next_status;                // [R8] [R12]
        reply_cmd_o    <= frame[1];
      end
    end
  end
endmodule

/* common/irq_ctrl_pkg.sv */
// Shared constants for the command interrupt control block
package irq_ctrl_pkg;
  // ****************************************************************
  // Instruction codes and special values
  // ****************************************************************
  localparam logic [7:0] OP_IRQ_ENABLE     = 8'h19; // 25
  localparam logic [7:0] OP_IRQ_DISABLE    = 8'h1A; // 26
  localparam logic [7:0] OP_VECTOR_DEFINE  = 8'h25; // 37
  localparam logic [7:0] OP_HANDLER_RETURN = 8'h26; // 38
  localparam logic [7:0] IRQ_GLOBAL        = 8'hFF; // 255
  localparam logic [7:0] STATUS_OK         = 8'h64; // 100
  localparam logic [7:0] STATUS_BAD_SUM    = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD    = 8'h02;
  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int          IRQ_COUNT       = 16;
  localparam int          IRQ_IDX_W       = 4;
  localparam int          PC_W            = 16;
  localparam int          FRAME_BYTES     = 9;
  localparam logic        GLOBAL_EN_RESET = 1'b0;
  localparam logic [15:0] PC_RESET        = 16'h0000;
endpackage

/* logic/vector_table.sv */
// Small memory holding one handler entry address per interrupt number
`timescale 1ns/1ps
module vector_table #(
  parameter int DEPTH  = 16,
  parameter int ADDR_W = 4,
  parameter int DATA_W = 16
) (
  // Clock
  input  wire logic              mclk_i,
  // Write port
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] mem [DEPTH];

  // Write stores over any older entry, read is registered
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

/* tb/host_model.sv */
// Host model sending binary command frames to the block
`timescale 1ns/1ps
module host_model (
  // Clock and frame byte stream
  input  wire logic       mclk_i,
  output logic            frame_valid_o,
  output logic      [7:0] frame_byte_o
);
  localparam logic [7:0] TARGET = 8'h01; // Arbitrary module address
  // Idle line
  initial frame_valid_o = 1'b0;
  initial frame_byte_o = 8'hA5;
  // Sends nine bytes; the last is the sum, inverted when bad is set
  task automatic send(input logic [7:0] op, kind, input logic [31:0] v,
                      input logic bad);
    logic [7:0] b [9];
    b = '{TARGET, op, kind, 8'h5A, v[31:24], v[23:16], v[15:8], v[7:0],
          8'h00};
    for (int i = 0; i < 8; i++) b[8] += b[i];
    if (bad) b[8] = ~b[8];
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk_i);
      frame_valid_o <= 1'b1;
      frame_byte_o  <= b[i];
    end
    @(posedge mclk_i);
    frame_valid_o <= 1'b0;
    frame_byte_o  <= ~b[8]; // Released line shows no stale byte
  endtask
endmodule

/* tb/irq_ctrl_chk.sv */
// Assertion checker for the command interrupt control block
`timescale 1ns/1ps
module irq_ctrl_chk #(
  parameter int IRQ_COUNT = 16
) (
  // Watched ports
  input wire logic                 mclk_i,
  input wire logic                 reset_i,
  input wire logic                 frame_valid_i,
  input wire logic [7:0]           frame_byte_i,
  input wire logic                 prog_valid_i,
  input wire logic [7:0]           prog_op_i,
  input wire logic [7:0]           prog_type_i,
  input wire logic [IRQ_COUNT-1:0] irq_req_i,
  input wire logic                 reply_valid_o,
  input wire logic [7:0]           reply_status_o,
  input wire logic                 ctx_load_o,
  input wire logic                 global_en_o,
  input wire logic [IRQ_COUNT-1:0] irq_en_o,
  input wire logic                 in_handler_o
);
  logic [3:0] cnt;
  logic [7:0] sum;
  logic [7:0] op;
  logic       hcmd;
  // Frame end, checksum match and serviceable request
  wire last  = frame_valid_i && cnt == 4'h8;
  wire good  = last && frame_byte_i == sum;
  wire armed = global_en_o && !in_handler_o && |(irq_req_i & irq_en_o);
  wire known = op inside {irq_ctrl_pkg::OP_IRQ_ENABLE,
    irq_ctrl_pkg::OP_IRQ_DISABLE, irq_ctrl_pkg::OP_VECTOR_DEFINE,
    irq_ctrl_pkg::OP_HANDLER_RETURN};
  default clocking dflt @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // A good host frame acts a cycle after its last byte and beats the program
  always_ff @(posedge mclk_i) begin
    hcmd <= good && !reset_i;
  end
  wire pv = prog_valid_i && !hcmd;
  // Counts frame bytes, sums the first eight, keeps the instruction
  always_ff @(posedge mclk_i) begin
    if (reset_i || last) begin
      cnt <= 4'h0;
      sum <= 8'h00;
    end else if (frame_valid_i) begin
      cnt <= cnt + 4'h1;
      sum <= sum + frame_byte_i;
      op  <= (cnt == 4'h1) ? frame_byte_i : op;
    end
  end
  // Handler entry three cycles on
  sequence s_entry;
    ##3 ctx_load_o && in_handler_o;
  endsequence
  a_reply_ok: assert property (good && known |-> ##2 reply_valid_o
    && reply_status_o == irq_ctrl_pkg::STATUS_OK) else $error("no ok");
  a_bad_sum: assert property (last && !good |-> ##2 reply_valid_o
    && reply_status_o == irq_ctrl_pkg::STATUS_BAD_SUM) else $error("sum");
  a_bad_cmd: assert property (good && !known |-> ##2 reply_valid_o
    && reply_status_o == irq_ctrl_pkg::STATUS_BAD_CMD) else $error("op");
  a_global_on: assert property (pv && prog_op_i == 8'h19
    && prog_type_i == 8'hFF |=> global_en_o) else $error("global on");
  a_global_off: assert property (pv && prog_op_i == 8'h1A
    && prog_type_i == 8'hFF |=> !global_en_o) else $error("global off");
  a_single_on: assert property (pv && prog_op_i == 8'h19
    && prog_type_i < 8'h10 |=> irq_en_o[$past(prog_type_i[3:0])])
    else $error("enable");
  a_single_off: assert property (pv && prog_op_i == 8'h1A
    && prog_type_i < 8'h10 |=> !irq_en_o[$past(prog_type_i[3:0])])
    else $error("disable");
  a_return_load: assert property (pv && in_handler_o
    && prog_op_i == 8'h26 |=> ctx_load_o) else $error("return");
  a_irq_entry: assert property (armed && !$past(armed) |-> s_entry)
    else $error("entry");
  a_irq_blocked: assert property ($rose(in_handler_o)
    |-> $past(global_en_o, 3)) else $error("blocked");
endmodule
bind command_interrupt_control irq_ctrl_chk #(.IRQ_COUNT(IRQ_COUNT))
  irq_ctrl_chk_i (.mclk_i, .reset_i, .frame_valid_i, .frame_byte_i,
  .prog_valid_i, .prog_op_i, .prog_type_i, .irq_req_i, .reply_valid_o,
  .reply_status_o, .ctx_load_o, .global_en_o, .irq_en_o, .in_handler_o);

/* tb/tb_top.sv */
// Self-checking bench for the command interrupt control block
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] OPS [4] = '{irq_ctrl_pkg::OP_IRQ_ENABLE,
    irq_ctrl_pkg::OP_IRQ_DISABLE, irq_ctrl_pkg::OP_VECTOR_DEFINE,
    irq_ctrl_pkg::OP_HANDLER_RETURN};
  logic        mclk_i = 1'b0, reset_i = 1'b1, prog_valid_i = 1'b0;
  logic [7:0]  prog_op_i = 8'h00, prog_type_i = 8'h00, flags_i = 8'h5A;
  logic [31:0] prog_value_i = 32'h0, accu_i = 32'h1111_2222;
  logic [31:0] xreg_i = 32'h3333_4444, accu_o, xreg_o;
  logic [15:0] irq_req_i = 16'h0, pc_i = 16'h0040, pc_o, irq_en_o;
  logic [7:0]  frame_byte_i, reply_status_o, reply_cmd_o, flags_o;
  logic        frame_valid_i, reply_valid_o, ctx_load_o;
  logic        global_en_o, in_handler_o;
  int          errors = 0, check_count = 0;
  // Device and host
  command_interrupt_control command_interrupt_control_i (.mclk_i,
    .reset_i, .frame_valid_i, .frame_byte_i, .prog_valid_i, .prog_op_i,
    .prog_type_i, .prog_value_i, .irq_req_i, .accu_i, .xreg_i, .flags_i,
    .pc_i, .reply_valid_o, .reply_status_o, .reply_cmd_o, .ctx_load_o,
    .accu_o, .xreg_o, .flags_o, .pc_o, .global_en_o, .irq_en_o,
    .in_handler_o);
  host_model host_model_i (.mclk_i, .frame_valid_o(frame_valid_i),
    .frame_byte_o(frame_byte_i));
  // Clock
  initial forever #20 mclk_i = ~mclk_i;
  // Compares and counts
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // Prints counts and verdict
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One stored-program instruction, taken at the second edge
  task automatic prog(input logic [7:0] op, kind, input logic [31:0] v);
    @(posedge mclk_i);
    prog_valid_i <= 1'b1;
    prog_op_i    <= op;
    prog_type_i  <= kind;
    prog_value_i <= v;
    @(posedge mclk_i);
    prog_valid_i <= 1'b0;
    #1;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    check({reply_valid_o, global_en_o, in_handler_o, irq_en_o}, 19'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      host_model_i.send(OPS[i], 8'hFF, 32'h1234_5678, 1'b0);
      @(posedge mclk_i);
      #1;
      check({reply_valid_o, reply_status_o},
            {1'b1, irq_ctrl_pkg::STATUS_OK});
      check(reply_cmd_o, OPS[i]);
      check(global_en_o, i == 0);
    end
    host_model_i.send(OPS[0], 8'hFF, 32'h0, 1'b1);
    @(posedge mclk_i);
    #1;
    check({reply_status_o, global_en_o}, 9'h002);
    host_model_i.send(8'h21, 8'h00, 32'h0, 1'b0);
    @(posedge mclk_i);
    #1;
    check(reply_status_o, irq_ctrl_pkg::STATUS_BAD_CMD);
    check(reply_cmd_o, 8'h21);
    $display("host frame test done");
    prog(OPS[0], 8'h03, 32'hFFFF_FFFF);
    prog(OPS[0], 8'h14, 32'h0);
    check(irq_en_o, 16'h0008);
    prog(OPS[0], irq_ctrl_pkg::IRQ_GLOBAL, 32'h0);
    check(global_en_o, 1'b1);
    prog(OPS[1], 8'h03, 32'h0);
    check({global_en_o, irq_en_o}, 17'h10000);
    prog(OPS[0], 8'h02, 32'h0);
    prog(OPS[0], 8'h03, 32'h0);
    prog(OPS[2], 8'h03, 32'h0000_0777);
    prog(OPS[2], 8'h02, 32'hABCD_0100);
    prog(OPS[2], 8'h02, 32'hABCD_0232);
    @(posedge mclk_i);
    irq_req_i <= 16'h000C;
    repeat (3) @(posedge mclk_i);
    #1;
    check({ctx_load_o, in_handler_o, pc_o}, 18'h30232);
    @(posedge mclk_i);
    irq_req_i <= 16'h0;
    accu_i    <= 32'h0;
    pc_i      <= 16'h0999;
    prog(OPS[3], 8'hFF, 32'h0);
    check({ctx_load_o, pc_o, flags_o}, 25'h100405A);
    check(accu_o, 32'h1111_2222);
    check(xreg_o, 32'h3333_4444);
    @(posedge mclk_i);
    #1;
    check(in_handler_o, 1'b0);
    prog(OPS[3], 8'hFF, 32'h0);
    check(ctx_load_o, 1'b0);
    prog(OPS[1], irq_ctrl_pkg::IRQ_GLOBAL, 32'h0);
    @(posedge mclk_i);
    irq_req_i <= 16'h0004;
    repeat (5) @(posedge mclk_i);
    #1;
    check({global_en_o, in_handler_o}, 2'b00);
    $display("program test done");
    stop_test();
  end
endmodule
